// *** hdl/tccu_link_if.sv ***
// Purpose: joins the capture/compare unit to its timer and conversion side
// Assumes: both ends share i_clk_sys
// Notes: no clocking block; the bench joins the two ends
`timescale 1ns/10ps
interface tccu_link_if;
   import tccu_pkg::*;
   // timer count and its advance strobe
   logic [TCCU_CNT_W-1:0] timer_count;
   logic timer_tick;
   // special event request from the unit to the timer side
   logic special_event;
   // unit event flag, shown to the timer side for information only
   logic unit_irq;
   modport unit (
      input timer_count, timer_tick,
      output special_event, unit_irq
   );
   modport timer (
      output timer_count, timer_tick,
      input special_event, unit_irq
   );
endinterface

// *** hdl/tccu_pkg.sv ***
// Purpose: shared constants and types for the capture/compare unit and its timer side
// Assumes: one system clock, 16-bit timer count, 8-bit register port
// Notes: register offsets are local to the controller register port
package tccu_pkg;
   // ==========================================
   // widths
   localparam int TCCU_CNT_W = 16;
   localparam int TCCU_REG_W = 8;
   localparam int TCCU_ADR_W = 4;
   // ==========================================
   // unit register offsets
   localparam logic [3:0] TCCU_OFF_CONTROL = 4'h0;
   localparam logic [3:0] TCCU_OFF_VALUE_LOW = 4'h1;
   localparam logic [3:0] TCCU_OFF_VALUE_HIGH = 4'h2;
   localparam logic [3:0] TCCU_OFF_FLAGS = 4'h3;
   localparam logic [3:0] TCCU_OFF_ENABLE = 4'h4;
   localparam logic [3:0] TCCU_OFF_PINS = 4'h5;
   // timer side register offsets
   localparam logic [3:0] TCCU_OFF_TIMER_LOW = 4'h8;
   localparam logic [3:0] TCCU_OFF_TIMER_HIGH = 4'h9;
   localparam logic [3:0] TCCU_OFF_TIMER_CTRL = 4'hA;
   localparam logic [3:0] TCCU_OFF_TIMER_FLAGS = 4'hB;
   localparam logic [3:0] TCCU_OFF_TIMER_MASK = 4'hC;
   // ==========================================
   // field positions and reset values
   localparam int TCCU_MODE_LSB = 0;
   localparam int TCCU_MODE_W = 4;
   localparam logic [7:0] TCCU_CONTROL_RST = 8'h00;
   localparam int TCCU_FLAG_UNIT = 0;
   localparam int TCCU_FLAG_OVF = 0;
   localparam int TCCU_FLAG_SPECIAL = 1;
   localparam int TCCU_TCTRL_RUN = 0;
   localparam int TCCU_TCTRL_ADC = 1;
   localparam int TCCU_TCTRL_DIV_LSB = 4;
   localparam int TCCU_TCTRL_DIV_W = 4;
   localparam logic [7:0] TCCU_TCTRL_RST = 8'h00;
   // prescaler counts
   localparam logic [3:0] TCCU_PRE_4 = 4'h3;
   localparam logic [3:0] TCCU_PRE_16 = 4'hF;
   // ==========================================
   // mode field encodings
   localparam logic [3:0] TCCU_M_OFF = 4'h0;
   localparam logic [3:0] TCCU_M_TOGGLE = 4'h2;
   localparam logic [3:0] TCCU_M_CAP_FALL = 4'h4;
   localparam logic [3:0] TCCU_M_CAP_RISE = 4'h5;
   localparam logic [3:0] TCCU_M_CAP_RISE4 = 4'h6;
   localparam logic [3:0] TCCU_M_CAP_RISE16 = 4'h7;
   localparam logic [3:0] TCCU_M_SET = 4'h8;
   localparam logic [3:0] TCCU_M_CLEAR = 4'h9;
   localparam logic [3:0] TCCU_M_SOFT = 4'hA;
   localparam logic [3:0] TCCU_M_SPECIAL = 4'hB;
   typedef enum logic [1:0] {TCCU_CLS_IDLE, TCCU_CLS_CAPTURE, TCCU_CLS_COMPARE} tccu_class_t;
   // mode class decoding, used by the unit only
   function automatic tccu_class_t tccu_class(input logic [3:0] mode);
      if (mode[3:2] == 2'b01) begin
         return TCCU_CLS_CAPTURE;
      end else if (mode == TCCU_M_TOGGLE || mode[3:2] == 2'b10) begin
         return TCCU_CLS_COMPARE;
      end
      return TCCU_CLS_IDLE;
   endfunction
endpackage

// *** hdl/tccu_timer_side.sv ***
// Purpose: timer, conversion start and overflow flag facing the unit
// Assumes: timer counts in timer mode on i_clk_sys ticks, never asynchronously
// Notes: special event clears the count on the next tick, no overflow flag
`timescale 1ns/10ps
module tccu_timer_side
   import tccu_pkg::*;
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset,
   // register port
   input wire logic [tccu_pkg::TCCU_ADR_W-1:0] i_addr,
   input wire logic [tccu_pkg::TCCU_REG_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [tccu_pkg::TCCU_REG_W-1:0] o_rdata,
   // conversion start and interrupt
   output logic o_adc_start,
   output logic o_irq,
   // link to the unit
   tccu_link_if.timer link
);
   import tccu_pkg::*;

   // ==========================================
   // state
   logic [15:0] count;
   logic [7:0] tctrl;
   logic [3:0] div_count;
   logic [1:0] flags;
   logic [1:0] mask;

   wire run = tctrl[TCCU_TCTRL_RUN];
   wire [3:0] div = tctrl[TCCU_TCTRL_DIV_LSB +: TCCU_TCTRL_DIV_W];
   // synchronous timer mode only; tick from a system-clock divider
   wire tick = run && (div_count == div);
   wire overflow = tick && !link.special_event && (count == 16'hFFFF);
   wire wr_tl = i_wr && (i_addr == TCCU_OFF_TIMER_LOW);
   wire wr_th = i_wr && (i_addr == TCCU_OFF_TIMER_HIGH);
   assign link.timer_count = count;
   assign link.timer_tick = tick;
   assign o_irq = |(flags & mask);

   // ==========================================
   // divider and count
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         div_count <= 4'h0;
         count <= 16'h0000;
      end else begin
         div_count <= (tick || !run) ? 4'h0 : div_count + 4'h1;
         if (tick && link.special_event) begin
            count <= 16'h0000;
         end else if (wr_tl) begin
            count[7:0] <= i_wdata;
         end else if (wr_th) begin
            count[15:8] <= i_wdata;
         end else if (tick) begin
            count <= count + 16'h0001;
         end
      end
   end

   // ==========================================
   // control, flags (write one clears, set wins), mask, conversion start
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         tctrl <= TCCU_TCTRL_RST;
         flags <= 2'b00;
         mask <= 2'b00;
         o_adc_start <= 1'b0;
      end else begin
         if (i_wr && i_addr == TCCU_OFF_TIMER_CTRL) begin
            tctrl <= i_wdata;
         end
         if (i_wr && i_addr == TCCU_OFF_TIMER_MASK) begin
            mask <= i_wdata[1:0];
         end
         flags[TCCU_FLAG_OVF] <= overflow ||
            (flags[TCCU_FLAG_OVF] && !(i_wr && i_addr == TCCU_OFF_TIMER_FLAGS &&
             i_wdata[TCCU_FLAG_OVF]));
         flags[TCCU_FLAG_SPECIAL] <= (tick && link.special_event) ||
            (flags[TCCU_FLAG_SPECIAL] && !(i_wr && i_addr == TCCU_OFF_TIMER_FLAGS &&
             i_wdata[TCCU_FLAG_SPECIAL]));
         // one pulse per timer reset when conversions are enabled
         o_adc_start <= tick && link.special_event && tctrl[TCCU_TCTRL_ADC];
      end
   end

   // ==========================================
   // read data one cycle after the strobe
   wire [7:0] rd_mux = (i_addr == TCCU_OFF_TIMER_LOW) ? count[7:0] :
                       (i_addr == TCCU_OFF_TIMER_HIGH) ? count[15:8] :
                       (i_addr == TCCU_OFF_TIMER_CTRL) ? tctrl :
                       (i_addr == TCCU_OFF_TIMER_FLAGS) ? {6'h00, flags} :
                       (i_addr == TCCU_OFF_TIMER_MASK) ? {6'h00, mask} :
                       8'h00;
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= i_rd ? rd_mux : 8'h00;
      end
   end
endmodule

// *** hdl/tccu_unit.sv ***
// Purpose: capture and compare unit against a 16-bit timer count
// Assumes: timer count runs on i_clk_sys and steps only on timer_tick
// Notes: the event pin is synchronised by two flip-flops before use
//
// Notes on behaviour
// - capture copies full count, sets flag
// - modes 4-7 pick capture edge events
// - modes 2,8,9,10,11 pick compare actions
// - timer must run synchronously to this clock
// - software masks interrupt across mode changes
// - edge counter cleared when off or not capturing
// - exactly four prescaler settings via mode
// - prescaler switch keeps counter; write zero first
// - compare pair checked against count continuously
// - every compare mode sets flag on match
// - control write of zero lowers output latch
// - pin drives only with direction bit cleared
// - mode 10 flags only, pin driven low while direction bit cleared
// - mode 11 resets timer, starts conversion
// - event immediate; timer clears next tick
// - special event leaves overflow flag alone
// - match lost before tick cancels timer reset
`timescale 1ns/10ps
module tccu_unit
   import tccu_pkg::*;
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset,
   // register port
   input wire logic [tccu_pkg::TCCU_ADR_W-1:0] i_addr,
   input wire logic [tccu_pkg::TCCU_REG_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [tccu_pkg::TCCU_REG_W-1:0] o_rdata,
   // event pin, three signals
   input wire logic i_event_pin,
   output logic o_event_pin,
   output logic o_event_pin_oe,
   // interrupt
   output logic o_irq,
   // link to timer side
   tccu_link_if.unit link
);
   import tccu_pkg::*;

   // ==========================================
   // registers
   logic [7:0] control;
   logic [15:0] value_pair; // no reset: contents kept across resets
   logic unit_event_flag;
   logic unit_event_enable;
   logic pin_direction_bit;
   logic out_latch;
   logic [3:0] edge_count;
   logic pin_meta, pin_sync, pin_prev;
   logic match_prev;
   logic pending_reset;

   // ==========================================
   // decode
   wire [3:0] mode = control[TCCU_MODE_LSB +: TCCU_MODE_W];
   wire tccu_class_t cls = tccu_class(mode);
   wire is_capture = (cls == TCCU_CLS_CAPTURE);
   wire is_compare = (cls == TCCU_CLS_COMPARE);
   wire wr_control = i_wr && (i_addr == TCCU_OFF_CONTROL);
   wire wr_low = i_wr && (i_addr == TCCU_OFF_VALUE_LOW);
   wire wr_high = i_wr && (i_addr == TCCU_OFF_VALUE_HIGH);
   wire wr_flags = i_wr && (i_addr == TCCU_OFF_FLAGS);
   wire wr_enable = i_wr && (i_addr == TCCU_OFF_ENABLE);
   wire wr_pins = i_wr && (i_addr == TCCU_OFF_PINS);

   // ==========================================
   // capture edge detection on the synchronised pin
   wire rise = pin_sync && !pin_prev;
   wire fall = !pin_sync && pin_prev;
   wire pre4_hit = (edge_count[1:0] == TCCU_PRE_4[1:0]);
   wire pre16_hit = (edge_count == TCCU_PRE_16);
   wire capture_hit = (mode == TCCU_M_CAP_FALL && fall) ||
                      (mode == TCCU_M_CAP_RISE && rise) ||
                      (mode == TCCU_M_CAP_RISE4 && rise && pre4_hit) ||
                      (mode == TCCU_M_CAP_RISE16 && rise && pre16_hit);

   // ==========================================
   // compare against the value pair
   wire equal_now = (value_pair == link.timer_count);
   wire match_start = is_compare && equal_now && !match_prev;
   wire unit_event = (is_capture && capture_hit) || match_start;

   // ==========================================
   // special event: immediate, held until the timer's next tick
   wire special_mode = (mode == TCCU_M_SPECIAL);
   assign link.special_event = special_mode && equal_now &&
                               (match_start || pending_reset);
   assign link.unit_irq = unit_event_flag;

   // ==========================================
   // control and value registers
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         control <= TCCU_CONTROL_RST;
      end else if (wr_control) begin
         control <= i_wdata;
      end
   end

   // capture wins over a software write in the same cycle
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset && is_capture && capture_hit) begin
         value_pair <= link.timer_count;
      end else if (wr_low) begin
         value_pair[7:0] <= i_wdata;
      end else if (wr_high) begin
         value_pair[15:8] <= i_wdata;
      end
   end

   // ==========================================
   // prescaler counter; not cleared between capture modes
   always_ff @(posedge i_clk_sys) begin
      if (i_reset || !is_capture) begin
         edge_count <= 4'h0;
      end else if (rise) begin
         edge_count <= edge_count + 4'h1;
      end
   end

   // ==========================================
   // pin synchroniser and edge history
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         pin_prev <= 1'b0;
      end else begin
         pin_meta <= i_event_pin;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // ==========================================
   // match history and pending timer reset
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         match_prev <= 1'b0;
         pending_reset <= 1'b0;
      end else begin
         match_prev <= is_compare && equal_now;
         if (link.timer_tick || !special_mode || !equal_now) begin
            pending_reset <= 1'b0;
         end else if (match_start) begin
            pending_reset <= 1'b1;
         end
      end
   end

   // ==========================================
   // compare output latch
   always_ff @(posedge i_clk_sys) begin
      if (i_reset || (wr_control && i_wdata == 8'h00)) begin
         out_latch <= 1'b0;
      end else if (match_start) begin
         case (mode)
            TCCU_M_TOGGLE: out_latch <= !out_latch;
            TCCU_M_SET: out_latch <= 1'b1;
            TCCU_M_CLEAR: out_latch <= 1'b0;
            default: out_latch <= out_latch;
         endcase
      end
   end

   // ==========================================
   // flag, enable and pin direction; set beats clear
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         unit_event_flag <= 1'b0;
         unit_event_enable <= 1'b0;
         pin_direction_bit <= 1'b1;
      end else begin
         if (unit_event) begin
            unit_event_flag <= 1'b1;
         end else if (wr_flags && i_wdata[TCCU_FLAG_UNIT]) begin
            unit_event_flag <= 1'b0;
         end
         if (wr_enable) begin
            unit_event_enable <= i_wdata[TCCU_FLAG_UNIT];
         end
         if (wr_pins) begin
            pin_direction_bit <= i_wdata[0];
         end
      end
   end

   // ==========================================
   // pin drive: enable from direction bit alone; level from latch only in pin-driving compare modes
   wire drives_pin = (mode == TCCU_M_TOGGLE) || (mode == TCCU_M_SET) ||
                     (mode == TCCU_M_CLEAR);
   assign o_event_pin_oe = !pin_direction_bit;
   assign o_event_pin = drives_pin && out_latch;
   assign o_irq = unit_event_flag && unit_event_enable;

   // ==========================================
   // read data one cycle after the strobe
   wire [7:0] rd_mux = (i_addr == TCCU_OFF_CONTROL) ? control :
                       (i_addr == TCCU_OFF_VALUE_LOW) ? value_pair[7:0] :
                       (i_addr == TCCU_OFF_VALUE_HIGH) ? value_pair[15:8] :
                       (i_addr == TCCU_OFF_FLAGS) ? {7'h00, unit_event_flag} :
                       (i_addr == TCCU_OFF_ENABLE) ? {7'h00, unit_event_enable} :
                       (i_addr == TCCU_OFF_PINS) ? {6'h00, out_latch, pin_direction_bit} :
                       8'h00;
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         o_rdata <= rd_mux;
      end else begin
         o_rdata <= 8'h00;
      end
   end
endmodule

// *** sim/tb.sv ***
// Purpose: joins both ends and walks capture, compare and period modes
// Assumes: one shared register bus, unit and timer maps do not overlap
// Notes: timer is stopped while capturing so captured values are exact
`timescale 1ns/10ps
module tb;
   import tccu_pkg::*;
   logic i_clk_sys, i_reset, i_wr, i_rd, pin, ev_pin, ev_oe, irq_u, irq_t, adc, watch;
   logic [3:0] addr;
   logic [7:0] wdata, rd_u, rd_t;
   logic [15:0] cnt_max = 16'h0000;
   int error_cnt = 0, total_checks = 0, cycles = 0, adc_cnt = 0;
   int edges[4] = '{1, 1, 4, 16};
   logic [3:0] cmp_mode[4] = '{4'h2, 4'h9, 4'h8, 4'hA};
   logic cmp_pin[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   wire [7:0] rdata = rd_u | rd_t;
   tccu_link_if link();
   tccu_unit u_tccu_unit (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(addr),
      .i_wdata(wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rd_u), .i_event_pin(pin),
      .o_event_pin(ev_pin), .o_event_pin_oe(ev_oe), .o_irq(irq_u), .link(link));
   tccu_timer_side u_tccu_timer_side (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
      .i_addr(addr), .i_wdata(wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rd_t),
      .o_adc_start(adc), .o_irq(irq_t), .link(link));
   tccu_sva u_tccu_sva (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
      .timer_count(link.timer_count), .timer_tick(link.timer_tick),
      .special_event(link.special_event), .unit_irq(link.unit_irq));
   // ==========================================
   // clock, timeout and watchers
   initial begin
      i_clk_sys = 1'b0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) begin
      cycles++;
      if (adc === 1'b1) adc_cnt++;
      if (watch === 1'b1 && link.timer_count > cnt_max) cnt_max <= link.timer_count;
      if (cycles == 20000) begin
         error_cnt++;
         summarize();
      end
   end
   // ==========================================
   // bus and compare tasks
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      addr <= a;
      wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   // data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
      @(posedge i_clk_sys);
      addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      chk(name, {8'h00, exp}, {8'h00, rdata});
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge i_clk_sys);
         pin <= 1'b1;
         repeat (8) @(posedge i_clk_sys);
         pin <= 1'b0;
         repeat (8) @(posedge i_clk_sys);
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ==========================================
   // main sequence
   initial begin
      i_reset = 1'b1;
      {i_wr, i_rd, pin, watch} = 4'h0;
      addr = 4'h0;
      wdata = 8'h00;
      repeat (10) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      rd(TCCU_OFF_CONTROL, TCCU_CONTROL_RST, "control");
      rd(TCCU_OFF_PINS, 8'h01, "pins");
      rd(TCCU_OFF_TIMER_CTRL, TCCU_TCTRL_RST, "timer control");
      wr(4'h7, 8'hFF);
      rd(4'h7, 8'h00, "unmapped");
      chk("oe", 16'h0, {15'h0, ev_oe});
      // capture: each prescaler fires on its last edge only
      wr(TCCU_OFF_ENABLE, 8'h01);
      for (int i = 0; i < 4; i++) begin
         wr(TCCU_OFF_CONTROL, 8'h00);
         wr(TCCU_OFF_TIMER_LOW, 8'h34 + 8'(i));
         wr(TCCU_OFF_TIMER_HIGH, 8'h12);
         wr(TCCU_OFF_CONTROL, {4'h0, TCCU_M_CAP_FALL + 4'(i)});
         wr(TCCU_OFF_FLAGS, 8'h01);
         pulse(edges[i] - 1);
         rd(TCCU_OFF_FLAGS, 8'h00, "early flag");
         pulse(1);
         rd(TCCU_OFF_FLAGS, 8'h01, "capture flag");
         rd(TCCU_OFF_VALUE_LOW, 8'h34 + 8'(i), "value low");
         rd(TCCU_OFF_VALUE_HIGH, 8'h12, "value high");
         chk("irq", 16'h1, {15'h0, irq_u});
      end
      wr(TCCU_OFF_ENABLE, 8'h00);
      wr(TCCU_OFF_FLAGS, 8'h01);
      rd(TCCU_OFF_FLAGS, 8'h00, "flag cleared");
      chk("irq masked", 16'h0, {15'h0, irq_u});
      // compare: equality held long, acts once
      wr(TCCU_OFF_CONTROL, 8'h00);
      wr(TCCU_OFF_PINS, 8'h00);
      wr(TCCU_OFF_VALUE_LOW, 8'h40);
      wr(TCCU_OFF_VALUE_HIGH, 8'h00);
      wr(TCCU_OFF_TIMER_HIGH, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(TCCU_OFF_TIMER_LOW, 8'h00);
         wr(TCCU_OFF_CONTROL, {4'h0, cmp_mode[i]});
         wr(TCCU_OFF_FLAGS, 8'h01);
         wr(TCCU_OFF_TIMER_LOW, 8'h40);
         repeat (6) @(posedge i_clk_sys);
         #1;
         chk("pin", {15'h0, cmp_pin[i]}, {15'h0, ev_pin});
         rd(TCCU_OFF_FLAGS, 8'h01, "match flag");
      end
      chk("oe on", 16'h1, {15'h0, ev_oe});
      rd(TCCU_OFF_PINS, 8'h02, "latch kept");
      wr(TCCU_OFF_CONTROL, 8'h00);
      rd(TCCU_OFF_PINS, 8'h00, "latch low");
      // special event: a rewrite before the tick cancels the clear
      wr(TCCU_OFF_TIMER_LOW, 8'h00);
      wr(TCCU_OFF_VALUE_LOW, 8'h10);
      wr(TCCU_OFF_CONTROL, {4'h0, TCCU_M_SPECIAL});
      wr(TCCU_OFF_TIMER_LOW, 8'h10);
      wr(TCCU_OFF_VALUE_LOW, 8'h20);
      rd(TCCU_OFF_TIMER_LOW, 8'h10, "count kept");
      chk("event dropped", 16'h0, {15'h0, link.special_event});
      // running: value pair acts as period register
      wr(TCCU_OFF_TIMER_FLAGS, 8'h03);
      wr(TCCU_OFF_TIMER_MASK, 8'h02);
      watch <= 1'b1;
      wr(TCCU_OFF_TIMER_CTRL, 8'h03);
      repeat (100) @(posedge i_clk_sys);
      watch <= 1'b0;
      wr(TCCU_OFF_CONTROL, 8'h00);
      wr(TCCU_OFF_TIMER_CTRL, 8'h00);
      chk("period top", 16'h0020, cnt_max);
      chk("conversion", 16'h1, {15'h0, adc_cnt > 0});
      chk("timer irq", 16'h1, {15'h0, irq_t});
      rd(TCCU_OFF_TIMER_FLAGS, 8'h02, "timer flags");
      // plain wrap with a divided tick still raises the overflow flag
      wr(TCCU_OFF_TIMER_FLAGS, 8'h03);
      wr(TCCU_OFF_TIMER_LOW, 8'hFE);
      wr(TCCU_OFF_TIMER_HIGH, 8'hFF);
      wr(TCCU_OFF_TIMER_CTRL, 8'h11);
      repeat (8) @(posedge i_clk_sys);
      wr(TCCU_OFF_TIMER_CTRL, 8'h00);
      rd(TCCU_OFF_TIMER_FLAGS, 8'h01, "overflow flag");
      chk("timer irq masked", 16'h0, {15'h0, irq_t});
      // mid-run reset: control back to zero, value pair kept
      @(posedge i_clk_sys);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      rd(TCCU_OFF_CONTROL, TCCU_CONTROL_RST, "control after reset");
      rd(TCCU_OFF_VALUE_LOW, 8'h20, "value low kept");
      rd(TCCU_OFF_VALUE_HIGH, 8'h00, "value high kept");
      rd(TCCU_OFF_PINS, 8'h01, "pins after reset");
      chk("irq after reset", 16'h0, {15'h0, irq_u});
      summarize();
   end
endmodule

// *** sim/tccu_sva.sv ***
// Purpose: link checks between the unit and its timer side
// Assumes: one clock, synchronous active-high reset
// Notes: sees only the link, so register writes to the count stay out of its reach
`timescale 1ns/10ps
module tccu_sva (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset,
   // link signals
   input wire logic [15:0] timer_count,
   input wire logic timer_tick,
   input wire logic special_event,
   input wire logic unit_irq
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   // ==========================================
   // period reset steps
   sequence s_hit;
      special_event && timer_tick;
   endsequence
   sequence s_restart;
      timer_count == 16'h0000;
   endsequence
   property p_reset_clean;
      $fell(i_reset) |-> timer_count == 16'h0000 && !special_event && !unit_irq;
   endproperty
   property p_tick_step;
      timer_tick && !special_event |=> timer_count == $past(timer_count) + 16'h0001;
   endproperty
   // a pending event must not clear the count before the tick
   property p_hold;
      special_event && !timer_tick |=> timer_count == $past(timer_count);
   endproperty
   property p_special_clear;
      s_hit |=> s_restart;
   endproperty
   property p_special_once;
      s_hit and timer_count != 16'h0000 |=> !special_event [*2];
   endproperty
   property p_flag_on_event;
      $rose(special_event) |=> unit_irq;
   endproperty
   property p_special_bound;
      special_event |-> ##[0:16] (timer_tick || !special_event);
   endproperty
   property p_restart_step;
      s_hit ##1 timer_tick |=> timer_count == 16'h0001;
   endproperty
   a_reset_clean: assert property (p_reset_clean) else $error("state after reset");
   a_tick_step: assert property (p_tick_step) else $error("count step");
   a_hold: assert property (p_hold) else $error("count moved early");
   a_special_clear: assert property (p_special_clear) else $error("no period clear");
   a_special_once: assert property (p_special_once) else $error("event repeats");
   a_flag_on_event: assert property (p_flag_on_event) else $error("flag missing");
   a_special_bound: assert property (p_special_bound) else $error("event stuck");
   a_restart_step: assert property (p_restart_step) else $error("restart step");
endmodule
